// ---- accel_register_map_autoinc_tb.sv ----
// Self-checking bench for the sensor register map
`include "arm_defs.svh"
module accel_register_map_autoinc_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import arm_pkg::*;
	localparam logic [7:0] ID = 8'hA7; // Identity byte, value arbitrary
	logic          clk_sys = 1'b0;
	logic          rst_n = 1'b0;
	logic          device_active = 1'b0;
	logic          fast_read = 1'b0;
	arm_engine_t   engine;
	arm_bus_req_t  bus_req;
	logic [7:0]    rdata_q;
	logic [7:0]    r;
	logic          rvalid_q;
	logic          queue_pop_q;
	logic          write_refused_q;
	arm_rd_evt_t   rd_evt_q;
	arm_clr_t      debounce_clr_q;
	arm_cfg_bank_t cfg_q;
	int            err_total = 0;
	int            cmp_count = 0;
	int            cycles = 0;
	int            pops = 0;

	arm_register_map #(.PART_ID(ID)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus_req(bus_req), .device_active(device_active), .fast_read(fast_read),
		.engine(engine), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .rd_evt_q(rd_evt_q),
		.queue_pop_q(queue_pop_q), .debounce_clr_q(debounce_clr_q),
		.write_refused_q(write_refused_q), .cfg_q(cfg_q));
	arm_host_model i_host (.clk_sys(clk_sys), .rdata_q(rdata_q), .bus_req(bus_req));

	// Clock
	initial forever #10 clk_sys = ~clk_sys;
	// Cycle ceiling and pop counter
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (queue_pop_q === 1'b1) pops <= pops + 1;
		if (cycles == 4000) begin
			err_total++;
			close_out();
		end
	end

	function automatic logic [7:0] hi(input logic [13:0] s);
		return s[13:6];
	endfunction
	function automatic logic [7:0] lo(input logic [13:0] s);
		return {s[5:0], 2'b00};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic set(input logic [7:0] a);
		i_host.op(4'b1000, a, r);
	endtask
	task automatic rd(input logic [7:0] exp, input string what);
		i_host.op(4'b0100, 8'h00, r);
		chk(r, exp, what);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		set(a);
		i_host.op(4'b0010, d, r);
	endtask
	task automatic stop();
		i_host.op(4'b0001, 8'h00, r);
	endtask

	task automatic t_reset();
		logic [7:0] rv [12];
		rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h44, 8'h84, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 12; i++) chk(cfg_q[i], rv[i], "reset value");
		set(`ARM_A_CURRENT_MODE);
		rd(engine.sys_mode, "mode");
		rd(engine.int_cause, "cause");
		rd(ID, "identity");
		stop();
	endtask
	// Full burst from status through the wrap back to status
	task automatic t_burst_full();
		set(`ARM_A_DATA_STATUS);
		rd(engine.live_status, "live status");
		rd(hi(engine.x), "x high");
		rd(lo(engine.x), "x low");
		rd(hi(engine.y), "y high");
		rd(lo(engine.y), "y low");
		rd(hi(engine.z), "z high");
		rd(lo(engine.z), "z low");
		rd(engine.live_status, "wrap");
		stop();
	endtask
	task automatic t_burst_fast();
		fast_read = 1'b1;
		set(`ARM_A_X_HIGH);
		rd(hi(engine.x), "fast x");
		rd(hi(engine.y), "fast y");
		rd(hi(engine.z), "fast z");
		rd(engine.live_status, "fast wrap");
		stop();
		fast_read = 1'b0;
	endtask
	// Reserved places ignore writes and read zero
	task automatic t_reserved();
		logic [7:0] ra [8];
		ra = '{8'h07, 8'h08, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1F, 8'h40};
		foreach (ra[i]) begin
			wr(ra[i], 8'hFF);
			set(ra[i]);
			rd(8'h00, "reserved");
			stop();
		end
	endtask
	// Active mode refuses standby-only writes but takes debounce registers
	task automatic t_gate();
		device_active = 1'b1;
		wr(`ARM_A_RANGE_CONFIG, 8'h03);
		chk({7'h00, write_refused_q}, 8'h01, "refusal");
		chk(cfg_q[`ARM_I_RANGE_CONFIG], 8'h00, "refused value");
		wr(`ARM_A_FALL_THRESHOLD, 8'h11);
		chk({7'h00, debounce_clr_q.fall_threshold}, 8'h01, "threshold clear");
		chk(cfg_q[`ARM_I_FALL_THRESHOLD], 8'h11, "threshold value");
		wr(`ARM_A_ORIENT_DEBOUNCE, 8'h05);
		chk({7'h00, debounce_clr_q.orient_debounce}, 8'h01, "orient clear");
		wr(`ARM_A_FALL_DEBOUNCE, 8'h07);
		chk({7'h00, debounce_clr_q.fall_debounce}, 8'h01, "count clear");
		chk(cfg_q[`ARM_I_FALL_DEBOUNCE], 8'h07, "count value");
		device_active = 1'b0;
		wr(`ARM_A_RANGE_CONFIG, 8'h02);
		chk(cfg_q[`ARM_I_RANGE_CONFIG], 8'h02, "standby write");
		chk({7'h00, write_refused_q}, 8'h00, "no refusal");
		stop();
	endtask
	// Queue on: status swaps, entry point streams one set then restarts
	task automatic t_queue();
		wr(`ARM_A_QUEUE_SETUP, 8'h40);
		set(`ARM_A_DATA_STATUS);
		rd(engine.queue_status, "queue status");
		set(`ARM_A_X_HIGH);
		rd(hi(engine.qx), "qx high");
		rd(lo(engine.qx), "qx low");
		rd(hi(engine.qy), "qy high");
		rd(lo(engine.qy), "qy low");
		rd(hi(engine.qz), "qz high");
		chk(8'(pops), 8'h00, "early pop");
		rd(lo(engine.qz), "qz low");
		@(negedge clk_sys);
		chk(8'(pops), 8'h01, "pop count");
		rd(hi(engine.qx), "entry again");
		stop();
		fast_read = 1'b1;
		set(`ARM_A_X_HIGH);
		rd(hi(engine.qx), "fast qx");
		rd(hi(engine.qy), "fast qy");
		rd(hi(engine.qz), "fast qz");
		@(negedge clk_sys);
		chk(8'(pops), 8'h02, "fast pop count");
		set(`ARM_A_Y_HIGH);
		rd(hi(engine.y), "queue y high");
		rd(engine.queue_status, "fast y wrap");
		stop();
		fast_read = 1'b0;
		wr(`ARM_A_QUEUE_SETUP, 8'h00);
		stop();
	endtask
	task automatic t_stop();
		set(`ARM_A_Y_HIGH);
		rd(hi(engine.y), "y before stop");
		stop();
		rd(engine.live_status, "after stop");
		chk({7'h00, rvalid_q}, 8'h01, "answer valid");
		chk(rd_evt_q.addr, `ARM_A_DATA_STATUS, "read address");
	endtask

	task automatic close_out();
		$display("counts: %0d mismatches, %0d comparisons", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		engine = '{live_status: 8'hA5, queue_status: 8'h5A, sys_mode: 8'h01,
			int_cause: 8'h02, orient_state: 8'h03, fall_source: 8'h04, jolt_source: 8'h06,
			x: 14'h2A5C, y: 14'h1337, z: 14'h0F0F, qx: 14'h3FC1, qy: 14'h0042, qz: 14'h2468};
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_burst_full();
		t_burst_fast();
		t_reserved();
		t_gate();
		t_queue();
		t_stop();
		close_out();
	end
endmodule

// ---- arm_cfg_reg.sv ----
// One writable configuration byte with standby gating and optional debounce clear
module arm_cfg_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter bit         ANYTIME   = 1'b0,
	parameter bit         CLEARS    = 1'b0
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Write side
	input  wire logic       sel,
	input  wire logic [7:0] wdata,
	input  wire logic       active,
	// Results
	output logic      [7:0] q,
	output logic            clr_q,
	output logic            refused
);

	logic accept;

	// Writes land only in standby unless the byte is free to change
	assign accept  = sel && (ANYTIME || !active);
	assign refused = sel && !accept;

	// Storage and one-cycle clear pulse
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q     <= RESET_VAL;
			clr_q <= 1'b0;
		end else begin
			if (accept) begin
				q <= wdata;
			end
			clr_q <= accept && CLEARS;
		end
	end

endmodule

// ---- arm_defs.svh ----
// Register offsets, reset values, field positions and counts of the sensor register map
`ifndef ARM_DEFS_SVH
`define ARM_DEFS_SVH

// Register offsets
`define ARM_A_DATA_STATUS        8'h00
`define ARM_A_X_HIGH             8'h01
`define ARM_A_X_LOW              8'h02
`define ARM_A_Y_HIGH             8'h03
`define ARM_A_Y_LOW              8'h04
`define ARM_A_Z_HIGH             8'h05
`define ARM_A_Z_LOW              8'h06
`define ARM_A_QUEUE_SETUP        8'h09
`define ARM_A_QUEUE_TRIGGER_MAP  8'h0A
`define ARM_A_CURRENT_MODE       8'h0B
`define ARM_A_INTERRUPT_CAUSE    8'h0C
`define ARM_A_PART_IDENTITY      8'h0D
`define ARM_A_RANGE_CONFIG       8'h0E
`define ARM_A_HIGHPASS_CUTOFF    8'h0F
`define ARM_A_ORIENT_STATE       8'h10
`define ARM_A_ORIENT_CONFIG      8'h11
`define ARM_A_ORIENT_DEBOUNCE    8'h12
`define ARM_A_ORIENT_TILT        8'h13
`define ARM_A_ORIENT_TRIP        8'h14
`define ARM_A_FALL_CONFIG        8'h15
`define ARM_A_FALL_SOURCE        8'h16
`define ARM_A_FALL_THRESHOLD     8'h17
`define ARM_A_FALL_DEBOUNCE      8'h18
`define ARM_A_JOLT_CONFIG        8'h1D
`define ARM_A_JOLT_SOURCE        8'h1E

// Reset values of the writable registers
`define ARM_R_ZERO               8'h00
`define ARM_R_ORIENT_CONFIG      8'h80
`define ARM_R_ORIENT_TILT        8'h44
`define ARM_R_ORIENT_TRIP        8'h84

// Queue mode field inside queue_setup
`define ARM_QMODE_MSB            7
`define ARM_QMODE_LSB            6

// Sample split: high byte is sample[13:6], low byte holds sample[5:0] in [7:2]
`define ARM_SMP_HI_MSB           13
`define ARM_SMP_HI_LSB           6
`define ARM_SMP_LO_MSB           5
`define ARM_SMP_LO_PAD           2'b00

// Writable bank: count and slot of each register
`define ARM_NCFG                 12
`define ARM_I_QUEUE_SETUP        0
`define ARM_I_QUEUE_TRIGGER_MAP  1
`define ARM_I_RANGE_CONFIG       2
`define ARM_I_HIGHPASS_CUTOFF    3
`define ARM_I_ORIENT_CONFIG      4
`define ARM_I_ORIENT_DEBOUNCE    5
`define ARM_I_ORIENT_TILT        6
`define ARM_I_ORIENT_TRIP        7
`define ARM_I_FALL_CONFIG        8
`define ARM_I_FALL_THRESHOLD     9
`define ARM_I_FALL_DEBOUNCE      10
`define ARM_I_JOLT_CONFIG        11

`endif

// ---- arm_host_model.sv ----
// Host bus-master model issuing byte requests to the register map
module arm_host_model (
	// Clock and read answer
	input wire logic           clk_sys,
	input wire logic [7:0]     rdata_q,
	// Requests
	output arm_pkg::arm_bus_req_t bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import arm_pkg::*;
	initial bus_req = '0;
	// One request held across its taking edge, then an idle cycle
	task automatic op(input logic [3:0] kind, input logic [7:0] d, output logic [7:0] r);
		@(negedge clk_sys);
		bus_req <= {kind, d};
		@(negedge clk_sys);
		// Idle data is inverted so a stale byte is never mistaken for a fresh one
		bus_req <= {4'h0, ~d};
		r = rdata_q;
	endtask
endmodule

// ---- arm_map_props.sv ----
// Concurrent checks on the sensor register map ports
`include "arm_defs.svh"
module arm_map_props (
	// Clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	// Inputs
	input wire arm_pkg::arm_bus_req_t bus_req,
	input wire logic                  device_active,
	input wire logic                  fast_read,
	input wire arm_pkg::arm_engine_t  engine,
	// Outputs
	input wire logic [7:0]            rdata_q,
	input wire logic                  rvalid_q,
	input wire arm_pkg::arm_rd_evt_t  rd_evt_q,
	input wire logic                  queue_pop_q,
	input wire arm_pkg::arm_clr_t     debounce_clr_q,
	input wire logic                  write_refused_q,
	input wire arm_pkg::arm_cfg_bank_t cfg_q
);
	import arm_pkg::*;
	// Taken requests, by the port's priority
	wire rd_go = bus_req.rd && !bus_req.set_addr && !bus_req.stop;
	wire wr_go = bus_req.wr && !bus_req.set_addr && !bus_req.stop && !bus_req.rd;
	wire q_on = cfg_q[`ARM_I_QUEUE_SETUP][7:6] != 2'b00;
	wire [7:0] ea = rd_evt_q.addr;
	// Sample behind the answered address
	wire [13:0] smp = (ea < 8'h03) ? engine.x : (ea < 8'h05) ? engine.y : engine.z;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Answer at a, an idle cycle, then the next read: pointer step is visible
	sequence hop(logic [7:0] a);
		rvalid_q && ea == a && !bus_req.set_addr && !bus_req.stop && !bus_req.rd
			&& !bus_req.wr ##1 rd_go;
	endsequence
	a_read_answers: assert property (rd_go |=> rvalid_q && rd_evt_q.valid)
		else $error("read not answered");
	a_reserved_zero: assert property (rvalid_q && ea inside {8'h07, 8'h08, [8'h19:8'hFF]}
		&& ea != 8'h1D && ea != 8'h1E |-> rdata_q == 8'h00)
		else $error("reserved read not zero");
	a_status_select: assert property (rvalid_q && ea == 8'h00 |-> rdata_q ==
		(q_on ? engine.queue_status : engine.live_status)) else $error("status select");
	a_sample_bytes: assert property (rvalid_q && !q_on && ea inside {[8'h01:8'h06]}
		|-> rdata_q == (ea[0] ? smp[13:6] : {smp[5:0], 2'b00})) else $error("sample byte");
	a_after_x_high: assert property (hop(8'h01)
		|=> ea == (q_on ? 8'h01 : fast_read ? 8'h03 : 8'h02)) else $error("step after x");
	a_y_high_step: assert property (hop(8'h03) ##0 !q_on
		|=> ea == (fast_read ? 8'h05 : 8'h04)) else $error("step after y");
	a_z_wrap_step: assert property (hop(8'h05) |=> ea == (fast_read ? 8'h00 : 8'h06))
		else $error("step after z");
	a_stop_discard: assert property (bus_req.stop && !bus_req.set_addr ##1
		!bus_req.set_addr && !bus_req.rd && !bus_req.wr ##1 rd_go |=> ea == 8'h00)
		else $error("stop kept");
	a_clear_on_write: assert property ($changed(cfg_q[`ARM_I_FALL_THRESHOLD])
		|-> debounce_clr_q.fall_threshold) else $error("no debounce clear");
	a_standby_only: assert property ($changed(cfg_q[`ARM_I_RANGE_CONFIG])
		|-> !$past(device_active)) else $error("active write taken");
	a_refuse_cause: assert property (write_refused_q |-> $past(wr_go && device_active))
		else $error("stray refusal");
	a_pop_on_entry: assert property (queue_pop_q |-> rvalid_q && ea == 8'h01 && q_on)
		else $error("stray pop");
endmodule

bind arm_register_map arm_map_props i_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.bus_req(bus_req), .device_active(device_active), .fast_read(fast_read),
	.engine(engine), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .rd_evt_q(rd_evt_q),
	.queue_pop_q(queue_pop_q), .debounce_clr_q(debounce_clr_q),
	.write_refused_q(write_refused_q), .cfg_q(cfg_q));

// ---- arm_next_addr.sv ----
// Next burst-read address, shaped by queue mode and fast read
`include "arm_defs.svh"
module arm_next_addr (
	// Inputs
	input  wire logic [7:0] addr,
	input  wire logic       queue_on,
	input  wire logic       fast,
	// Result
	output logic      [7:0] next
);

	logic [7:0] plain_next;

	// Plain step; 8-bit wrap is harmless since the top of the map reads zero
	assign plain_next = 8'(addr + 8'h01);

	// Sample area has its own jumps, everything else just steps
	always_comb begin
		next = plain_next;
		unique case (addr)
			`ARM_A_X_HIGH: next = queue_on ? `ARM_A_X_HIGH :
				(fast ? `ARM_A_Y_HIGH : `ARM_A_X_LOW);
			`ARM_A_X_LOW:  next = fast ? `ARM_A_DATA_STATUS : `ARM_A_Y_HIGH;
			`ARM_A_Y_HIGH: next = !fast ? `ARM_A_Y_LOW :
				(queue_on ? `ARM_A_DATA_STATUS : `ARM_A_Z_HIGH);
			`ARM_A_Y_LOW:  next = fast ? `ARM_A_DATA_STATUS : `ARM_A_Z_HIGH;
			`ARM_A_Z_HIGH: next = fast ? `ARM_A_DATA_STATUS : `ARM_A_Z_LOW;
			`ARM_A_Z_LOW:  next = `ARM_A_DATA_STATUS;
			default:       next = plain_next;
		endcase
	end

endmodule

// ---- arm_pkg.sv ----
// Types shared by the sensor register map and its neighbours
`include "arm_defs.svh"
package arm_pkg;

	// Byte-level request from the serial front end
	typedef struct packed {
		logic       set_addr;
		logic       rd;
		logic       wr;
		logic       stop;
		logic [7:0] data;
	} arm_bus_req_t;

	// Live values from the measurement and detection engines
	typedef struct packed {
		logic [7:0]  live_status;
		logic [7:0]  queue_status;
		logic [7:0]  sys_mode;
		logic [7:0]  int_cause;
		logic [7:0]  orient_state;
		logic [7:0]  fall_source;
		logic [7:0]  jolt_source;
		logic [13:0] x;
		logic [13:0] y;
		logic [13:0] z;
		logic [13:0] qx;
		logic [13:0] qy;
		logic [13:0] qz;
	} arm_engine_t;

	// Debounce counter clears toward the detection engines
	typedef struct packed {
		logic orient_debounce;
		logic fall_threshold;
		logic fall_debounce;
	} arm_clr_t;

	// Read notice so engines can clear read-sensitive flags
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
	} arm_rd_evt_t;

	// Writable bank, one byte per slot
	typedef logic [`ARM_NCFG-1:0][7:0] arm_cfg_bank_t;

	// Position inside one queued sample set
	typedef enum logic [5:0] {
		ARM_QB_XH = 6'b00_0001,
		ARM_QB_XL = 6'b00_0010,
		ARM_QB_YH = 6'b00_0100,
		ARM_QB_YL = 6'b00_1000,
		ARM_QB_ZH = 6'b01_0000,
		ARM_QB_ZL = 6'b10_0000
	} arm_qbyte_t;

endpackage

// ---- arm_register_map.sv ----
// Register map of the three-axis sensor with burst-read address sequencing
`include "arm_defs.svh"
module arm_register_map
	import arm_pkg::*;
#(
	// Identity byte; value is arbitrary
	parameter logic [7:0] PART_ID = 8'h5C
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Byte requests from the serial front end
	input  wire arm_pkg::arm_bus_req_t bus_req,
	// Mode inputs from the control block
	input  wire logic                 device_active,
	input  wire logic                 fast_read,
	// Engine values
	input  wire arm_pkg::arm_engine_t engine,
	// Read answer
	output logic      [7:0]           rdata_q,
	output logic                      rvalid_q,
	// Side effects toward the engines
	output arm_pkg::arm_rd_evt_t      rd_evt_q,
	output logic                      queue_pop_q,
	output arm_pkg::arm_clr_t         debounce_clr_q,
	output logic                      write_refused_q,
	// Configuration toward the engines
	output arm_pkg::arm_cfg_bank_t    cfg_q
);
	import arm_pkg::*;

	// Placement of the writable bank
	localparam logic [7:0] CFG_ADDR [`ARM_NCFG] = '{
		`ARM_A_QUEUE_SETUP, `ARM_A_QUEUE_TRIGGER_MAP, `ARM_A_RANGE_CONFIG,
		`ARM_A_HIGHPASS_CUTOFF, `ARM_A_ORIENT_CONFIG, `ARM_A_ORIENT_DEBOUNCE,
		`ARM_A_ORIENT_TILT, `ARM_A_ORIENT_TRIP, `ARM_A_FALL_CONFIG,
		`ARM_A_FALL_THRESHOLD, `ARM_A_FALL_DEBOUNCE, `ARM_A_JOLT_CONFIG
	};
	localparam logic [7:0] CFG_RST [`ARM_NCFG] = '{
		`ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_ZERO,
		`ARM_R_ZERO, `ARM_R_ORIENT_CONFIG, `ARM_R_ZERO,
		`ARM_R_ORIENT_TILT, `ARM_R_ORIENT_TRIP, `ARM_R_ZERO,
		`ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_ZERO
	};
	// Registers writable in either mode
	localparam bit CFG_FREE [`ARM_NCFG] = '{
		1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
		1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0
	};
	// Registers whose write restarts a debounce counter
	localparam bit CFG_CLR [`ARM_NCFG] = '{
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
		1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0
	};

	// Pointer and queue walk state
	logic       [7:0] addr_q;
	logic       [7:0] addr_d;
	arm_qbyte_t       qbyte_q;
	arm_qbyte_t       qbyte_d;

	// Decode and selection wires
	logic       [7:0] next_addr;
	logic             queue_on;
	logic             at_queue_port;
	logic             queue_read;
	logic             queue_last;
	logic       [7:0] rd_mux;
	logic       [7:0] queue_byte;
	logic       [7:0] sample_hi_x;
	logic       [7:0] sample_lo_x;
	logic       [7:0] sample_hi_y;
	logic       [7:0] sample_lo_y;
	logic       [7:0] sample_hi_z;
	logic       [7:0] sample_lo_z;
	logic       [7:0] status_byte;
	logic       [7:0] cfg_read;
	logic             rd_take;
	logic             wr_take;
	logic             write_refused;
	logic [`ARM_NCFG-1:0] wr_hit;
	logic [`ARM_NCFG-1:0] clr_w;
	logic [`ARM_NCFG-1:0] refused_w;

	// Queue mode nonzero means the sample queue is on
	assign queue_on = |cfg_q[`ARM_I_QUEUE_SETUP][`ARM_QMODE_MSB:`ARM_QMODE_LSB];

	// Taken requests by port priority: pointer load, then stop, then read, then write
	assign rd_take = bus_req.rd && !bus_req.set_addr && !bus_req.stop;
	assign wr_take = bus_req.wr && !bus_req.set_addr && !bus_req.stop && !bus_req.rd;

	// Writable bank, one slot per register
	genvar gi;
	generate
		for (gi = 0; gi < `ARM_NCFG; gi++) begin : g_cfg
			assign wr_hit[gi] = wr_take && (addr_q == CFG_ADDR[gi]);
			arm_cfg_reg #(
				.RESET_VAL (CFG_RST[gi]),
				.ANYTIME   (CFG_FREE[gi]),
				.CLEARS    (CFG_CLR[gi])
			) u_cfg (
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.sel     (wr_hit[gi]),
				.wdata   (bus_req.data),
				.active  (device_active),
				.q       (cfg_q[gi]),
				.clr_q   (clr_w[gi]),
				.refused (refused_w[gi])
			);
		end
	endgenerate

	// Debounce clears come straight from the slot flops
	assign debounce_clr_q.orient_debounce = clr_w[`ARM_I_ORIENT_DEBOUNCE];
	assign debounce_clr_q.fall_threshold  = clr_w[`ARM_I_FALL_THRESHOLD];
	assign debounce_clr_q.fall_debounce   = clr_w[`ARM_I_FALL_DEBOUNCE];
	assign write_refused = |refused_w;

	// Bank readback; at most one slot matches
	function automatic logic [7:0] bank_read(input logic [7:0] a, input arm_cfg_bank_t bank);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < `ARM_NCFG; i++) begin
			if (a == CFG_ADDR[i]) begin
				r = r | bank[i];
			end
		end
		return r;
	endfunction

	assign cfg_read = bank_read(addr_q, cfg_q);

	// Sample byte split shared by live and queued data
	function automatic logic [7:0] hi_byte(input logic [13:0] s);
		return s[`ARM_SMP_HI_MSB:`ARM_SMP_HI_LSB];
	endfunction
	function automatic logic [7:0] lo_byte(input logic [13:0] s);
		return {s[`ARM_SMP_LO_MSB:0], `ARM_SMP_LO_PAD};
	endfunction

	assign sample_hi_x = hi_byte(engine.x);
	assign sample_lo_x = lo_byte(engine.x);
	assign sample_hi_y = hi_byte(engine.y);
	assign sample_lo_y = lo_byte(engine.y);
	assign sample_hi_z = hi_byte(engine.z);
	assign sample_lo_z = lo_byte(engine.z);

	// Status byte flips meaning with the queue mode
	assign status_byte = queue_on ? engine.queue_status : engine.live_status;

	// Queued byte at the current walk position
	assign queue_byte =
		(qbyte_q == ARM_QB_XH) ? hi_byte(engine.qx) :
		(qbyte_q == ARM_QB_XL) ? lo_byte(engine.qx) :
		(qbyte_q == ARM_QB_YH) ? hi_byte(engine.qy) :
		(qbyte_q == ARM_QB_YL) ? lo_byte(engine.qy) :
		(qbyte_q == ARM_QB_ZH) ? hi_byte(engine.qz) :
		lo_byte(engine.qz);

	// Read data selection; anything not named reads the writable bank, and zero outside it
	always_comb begin
		rd_mux = 8'h00;
		unique case (addr_q)
			`ARM_A_DATA_STATUS:     rd_mux = status_byte;
			`ARM_A_X_HIGH:          rd_mux = queue_on ? queue_byte : sample_hi_x;
			`ARM_A_X_LOW:           rd_mux = sample_lo_x;
			`ARM_A_Y_HIGH:          rd_mux = sample_hi_y;
			`ARM_A_Y_LOW:           rd_mux = sample_lo_y;
			`ARM_A_Z_HIGH:          rd_mux = sample_hi_z;
			`ARM_A_Z_LOW:           rd_mux = sample_lo_z;
			`ARM_A_CURRENT_MODE:    rd_mux = engine.sys_mode;
			`ARM_A_INTERRUPT_CAUSE: rd_mux = engine.int_cause;
			`ARM_A_PART_IDENTITY:   rd_mux = PART_ID;
			`ARM_A_ORIENT_STATE:    rd_mux = engine.orient_state;
			`ARM_A_FALL_SOURCE:     rd_mux = engine.fall_source;
			`ARM_A_JOLT_SOURCE:     rd_mux = engine.jolt_source;
			default:                rd_mux = cfg_read;
		endcase
	end

	// Burst sequencing for the sample area
	arm_next_addr u_next (
		.addr     (addr_q),
		.queue_on (queue_on),
		.fast     (fast_read),
		.next     (next_addr)
	);

	// Queue port reads walk the sample set instead of the map
	assign at_queue_port = queue_on && (addr_q == `ARM_A_X_HIGH);
	assign queue_read    = rd_take && at_queue_port;
	assign queue_last    = fast_read ? (qbyte_q == ARM_QB_ZH) : (qbyte_q == ARM_QB_ZL);

	// Walk order: full read takes all six bytes, fast read the high bytes only
	always_comb begin
		qbyte_d = qbyte_q;
		if (bus_req.stop || bus_req.set_addr) begin
			qbyte_d = ARM_QB_XH;
		end else if (queue_read) begin
			unique case (qbyte_q)
				ARM_QB_XH: qbyte_d = fast_read ? ARM_QB_YH : ARM_QB_XL;
				ARM_QB_XL: qbyte_d = ARM_QB_YH;
				ARM_QB_YH: qbyte_d = fast_read ? ARM_QB_ZH : ARM_QB_YL;
				ARM_QB_YL: qbyte_d = ARM_QB_ZH;
				ARM_QB_ZH: qbyte_d = fast_read ? ARM_QB_XH : ARM_QB_ZL;
				ARM_QB_ZL: qbyte_d = ARM_QB_XH;
				default:   qbyte_d = ARM_QB_XH;
			endcase
		end
	end

	// Pointer: new address wins, then stop, then read or write stepping
	always_comb begin
		addr_d = addr_q;
		if (bus_req.set_addr) begin
			addr_d = bus_req.data;
		end else if (bus_req.stop) begin
			addr_d = `ARM_A_DATA_STATUS;
		end else if (bus_req.rd) begin
			addr_d = next_addr;
		end else if (bus_req.wr) begin
			addr_d = 8'(addr_q + 8'h01);
		end
	end

	// Pointer and walk state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_q  <= `ARM_A_DATA_STATUS;
			qbyte_q <= ARM_QB_XH;
		end else begin
			addr_q  <= addr_d;
			qbyte_q <= qbyte_d;
		end
	end

	// Read answer and side-effect pulses, all one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q         <= 8'h00;
			rvalid_q        <= 1'b0;
			rd_evt_q        <= '0;
			queue_pop_q     <= 1'b0;
			write_refused_q <= 1'b0;
		end else begin
			rvalid_q        <= rd_take;
			rd_evt_q.valid  <= rd_take;
			rd_evt_q.addr   <= addr_q;
			queue_pop_q     <= queue_read && queue_last;
			write_refused_q <= write_refused;
			if (rd_take) begin
				rdata_q <= rd_mux;
			end
		end
	end

endmodule
